// ==== logic/add_bit_exec.sv ====
// Notes on behaviour
// [RULE1] literal add puts acc plus an 8-bit literal into acc and updates carry, half carry, zero.
// [RULE2] register add sums acc with the addressed file register and updates carry, half, zero.
// [RULE3] on register-operand ops destination 0 writes acc, destination 1 writes the register.
// [RULE4] literal and puts acc and literal into acc and changes only the zero flag.
// [RULE5] register and sends acc and register to the chosen destination, zero flag only.
// [RULE6] single_bit_zero forces the chosen bit of the register to 0, flags untouched.
// [RULE7] single_bit_one forces the chosen bit of the register to 1, flags untouched.
// [RULE8] test_skip_if_low discards the next instruction when the bit is 0, flags untouched.
// [RULE9] test_skip_if_high discards the next instruction when the bit is 1, flags untouched.
// [RULE10] a taken skip or a program counter change costs two cycles, the second a no-op.
// [RULE11] a write to first_timer_count clears the prescaler when it belongs to that timer.
// [RULE12] adds set carry from bit 7, half carry from bit 3, zero on an all-zero result.
// [RULE13] bit clear and set rewrite the whole register and keep the other seven bits.
`default_nettype none
module add_bit_exec (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [13:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  file_data,
  input  wire logic        presc_on_timer,
  output logic      [7:0]  acc_q,
  output logic             carry_q,
  output logic             half_carry_flag_q,
  output logic             zero_q,
  output logic             wr_en_q,
  output logic      [6:0]  wr_addr_q,
  output logic      [7:0]  wr_data_q,
  output logic             discard_q,
  output logic             presc_clr_q
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  datapath_if dp ();
  add_unit u_add (.dp(dp));
  bit_unit u_bit (.dp(dp));

  exec_pkg::seq_e st_q;
  exec_pkg::seq_e st_d;
  logic [7:0] acc_d;
  logic       carry_d;
  logic       half_d;
  logic       zero_d;
  logic       wr_en_d;
  logic [6:0] wr_addr_d;
  logic [7:0] wr_data_d;
  logic       discard_d;
  logic       presc_clr_d;

  logic [1:0] cls;
  logic       dest;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic       exec;
  logic       is_add_reg;
  logic       is_and_reg;
  logic       is_bclr;
  logic       is_bset;
  logic       is_tlow;
  logic       is_thigh;
  logic       is_add_lit;
  logic       is_and_lit;
  logic       is_jump;
  logic [7:0] and_res;

  assign cls      = instr[exec_pkg::CLS_HI:exec_pkg::CLS_LO];
  assign dest     = instr[exec_pkg::DEST_POS];
  assign faddr    = instr[exec_pkg::AW-1:0];
  assign lit      = instr[exec_pkg::LIT_HI:exec_pkg::LIT_LO];
  // only instructions met in execute state act; one met in the nop slot is dropped
  assign exec     = instr_valid && (st_q == exec_pkg::ST_EXEC);
  assign is_add_reg = exec && cls == exec_pkg::CLS_BYTE
                      && instr[exec_pkg::BOP_HI:exec_pkg::BOP_LO] == exec_pkg::OP_ADD_REG;
  assign is_and_reg = exec && cls == exec_pkg::CLS_BYTE
                      && instr[exec_pkg::BOP_HI:exec_pkg::BOP_LO] == exec_pkg::OP_AND_REG;
  assign is_bclr  = exec && cls == exec_pkg::CLS_BIT
                    && instr[exec_pkg::BITOP_HI:exec_pkg::BITOP_LO] == exec_pkg::OP_BCLR;
  assign is_bset  = exec && cls == exec_pkg::CLS_BIT
                    && instr[exec_pkg::BITOP_HI:exec_pkg::BITOP_LO] == exec_pkg::OP_BSET;
  assign is_tlow  = exec && cls == exec_pkg::CLS_BIT
                    && instr[exec_pkg::BITOP_HI:exec_pkg::BITOP_LO] == exec_pkg::OP_TSTLOW;
  assign is_thigh = exec && cls == exec_pkg::CLS_BIT
                    && instr[exec_pkg::BITOP_HI:exec_pkg::BITOP_LO] == exec_pkg::OP_TSTHIGH;
  assign is_add_lit = exec && cls == exec_pkg::CLS_LIT
                      && instr[exec_pkg::BOP_HI:exec_pkg::LADD_LO] == exec_pkg::OP_ADD_LIT;
  assign is_and_lit = exec && cls == exec_pkg::CLS_LIT
                      && instr[exec_pkg::BOP_HI:exec_pkg::BOP_LO] == exec_pkg::OP_AND_LIT;
  assign is_jump  = exec && cls == exec_pkg::CLS_JUMP;

  // one adder serves both add forms: the literal replaces the file operand
  assign dp.acc     = acc_q;
  assign dp.operand = is_add_lit ? lit : file_data;  // [RULE1] [RULE2]
  assign dp.bit_sel = instr[exec_pkg::BIT_HI:exec_pkg::BIT_LO];
  assign and_res    = acc_q & (is_and_lit ? lit : file_data);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d        = st_q;
    acc_d       = acc_q;
    carry_d     = carry_q;
    half_d      = half_carry_flag_q;
    zero_d      = zero_q;
    wr_en_d     = 1'b0;
    wr_addr_d   = wr_addr_q;
    wr_data_d   = wr_data_q;
    discard_d   = 1'b0;
    case (st_q)
      exec_pkg::ST_EXEC: begin
        if (is_add_lit) begin
          acc_d   = dp.sum;                  // [RULE1]
          carry_d = dp.carry;                // [RULE12]
          half_d  = dp.half;
          zero_d  = (dp.sum == 8'h00);
        end
        if (is_add_reg) begin
          carry_d = dp.carry;                // [RULE2] [RULE12]
          half_d  = dp.half;
          zero_d  = (dp.sum == 8'h00);
        end
        if (is_and_lit) begin
          acc_d  = and_res;                  // [RULE4]
          zero_d = (and_res == 8'h00);
        end
        if (is_and_reg) begin
          zero_d = (and_res == 8'h00);       // [RULE5]
        end
        if (is_add_reg || is_and_reg) begin
          if (dest == exec_pkg::DEST_FILE) begin
            wr_en_d   = 1'b1;                // [RULE3]
            wr_addr_d = faddr;
            wr_data_d = is_add_reg ? dp.sum : and_res;
          end else begin
            acc_d = is_add_reg ? dp.sum : and_res;  // [RULE3]
          end
        end
        if (is_bclr || is_bset) begin
          wr_en_d   = 1'b1;                  // [RULE13]
          wr_addr_d = faddr;
          wr_data_d = is_bclr ? dp.cleared : dp.setv;  // [RULE6] [RULE7]
        end
        if ((is_tlow && !dp.tested) || (is_thigh && dp.tested) || is_jump) begin
          st_d = exec_pkg::ST_NOP;           // [RULE8] [RULE9] [RULE10]
        end
      end
      exec_pkg::ST_NOP: begin
        // the discarded word must still arrive; the slot waits for it
        if (instr_valid) begin
          discard_d = 1'b1;                  // [RULE10]
          st_d      = exec_pkg::ST_EXEC;
        end
      end
      default: st_d = exec_pkg::ST_EXEC;
    endcase
    // writes to the timer count restart its prescaler when presc_on_timer is set
    presc_clr_d = wr_en_d && (wr_addr_d == exec_pkg::TIMER_ADDR)
                  && presc_on_timer;         // [RULE11]
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q              <= exec_pkg::ST_EXEC;
      acc_q             <= exec_pkg::ACC_RST;
      carry_q           <= exec_pkg::FLAG_RST;
      half_carry_flag_q <= exec_pkg::FLAG_RST;
      zero_q            <= exec_pkg::FLAG_RST;
      wr_en_q           <= 1'b0;
      wr_addr_q         <= 7'h00;
      wr_data_q         <= 8'h00;
      discard_q         <= 1'b0;
      presc_clr_q       <= 1'b0;
    end else begin
      st_q              <= st_d;
      acc_q             <= acc_d;
      carry_q           <= carry_d;
      half_carry_flag_q <= half_d;
      zero_q            <= zero_d;
      wr_en_q           <= wr_en_d;
      wr_addr_q         <= wr_addr_d;
      wr_data_q         <= wr_data_d;
      discard_q         <= discard_d;
      presc_clr_q       <= presc_clr_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_add_lit_sum: assert property ( // [RULE1]
    is_add_lit |=> acc_q == 8'($past(acc_q) + $past(lit))
                   && carry_q == (({1'b0, $past(acc_q)} + {1'b0, $past(lit)}) > 9'h0ff))
    else $error("literal add result or carry wrong");
  a_add_lit_half: assert property ( // [RULE12]
    is_add_lit |=> half_carry_flag_q
                   == ((5'($past(acc_q[3:0])) + 5'($past(lit[3:0]))) > 5'h0f)
                   && zero_q == (acc_q == 8'h00))
    else $error("literal add half carry or zero wrong");
  a_add_reg_file: assert property ( // [RULE3]
    is_add_reg && dest |=> wr_en_q && wr_addr_q == $past(faddr)
                           && wr_data_q == 8'($past(acc_q) + $past(file_data))
                           && $stable(acc_q))
    else $error("register add to file misrouted");
  a_add_reg_acc: assert property ( // [RULE2]
    is_add_reg && !dest |=> !wr_en_q && acc_q == 8'($past(acc_q) + $past(file_data)))
    else $error("register add to acc wrong");
  a_and_lit_flags: assert property ( // [RULE4]
    is_and_lit |=> acc_q == ($past(acc_q) & $past(lit)) && $stable(carry_q)
                   && $stable(half_carry_flag_q) && zero_q == (acc_q == 8'h00))
    else $error("literal and wrong");
  a_and_reg_dest: assert property ( // [RULE5]
    is_and_reg |=> (wr_en_q ? wr_data_q : acc_q) == ($past(acc_q) & $past(file_data))
                   && wr_en_q == $past(dest) && $stable(carry_q))
    else $error("register and wrong");
  a_bclr_rmw: assert property ( // [RULE6]
    is_bclr |=> wr_en_q && wr_data_q == ($past(file_data) & ~(8'h01 << $past(dp.bit_sel)))
                && $stable(carry_q) && $stable(zero_q) && $stable(half_carry_flag_q))
    else $error("bit clear wrong");
  a_bset_rmw: assert property ( // [RULE7]
    is_bset |=> wr_en_q && wr_data_q == ($past(file_data) | (8'h01 << $past(dp.bit_sel)))
                && $stable(carry_q) && $stable(zero_q) && $stable(acc_q))
    else $error("bit set wrong");
  a_skip_low: assert property ( // [RULE8]
    is_tlow |=> (st_q == exec_pkg::ST_NOP) == !$past(dp.tested) && $stable(zero_q))
    else $error("skip on low bit wrong");
  a_skip_high: assert property ( // [RULE9]
    is_thigh |=> (st_q == exec_pkg::ST_NOP) == $past(dp.tested) && $stable(carry_q))
    else $error("skip on high bit wrong");
  a_nop_slot: assert property ( // [RULE10]
    st_q == exec_pkg::ST_NOP && instr_valid |=> discard_q && !wr_en_q
                                                 && $stable(acc_q) && st_q == exec_pkg::ST_EXEC)
    else $error("discarded slot had an effect");
  a_timer_clear: assert property ( // [RULE11]
    presc_clr_q == (wr_en_q && wr_addr_q == exec_pkg::TIMER_ADDR && $past(presc_on_timer)))
    else $error("prescaler clear mismatch");

  // ----------------------------------------
  // flags, write port and slot checks
  // ----------------------------------------
  a_add_reg_flags: assert property ( // [RULE2] [RULE12]
    is_add_reg |=> carry_q == (({1'b0, $past(acc_q)} + {1'b0, $past(file_data)}) > 9'h0ff)
                   && half_carry_flag_q
                      == ((5'($past(acc_q[3:0])) + 5'($past(file_data[3:0]))) > 5'h0f)
                   && zero_q == (8'($past(acc_q) + $past(file_data)) == 8'h00))
    else $error("register add flags wrong");
  a_add_lit_port: assert property ( // [RULE1]
    is_add_lit |=> !wr_en_q && !presc_clr_q && !discard_q)
    else $error("literal add touched the write port");
  a_and_lit_port: assert property ( // [RULE4]
    is_and_lit |=> !wr_en_q && !presc_clr_q && !discard_q)
    else $error("literal and touched the write port");
  a_and_reg_zero: assert property ( // [RULE5]
    is_and_reg |=> zero_q == (($past(acc_q) & $past(file_data)) == 8'h00)
                   && $stable(half_carry_flag_q))
    else $error("register and zero flag wrong");
  a_and_reg_file: assert property ( // [RULE3]
    is_and_reg && dest |=> wr_en_q && wr_addr_q == $past(faddr)
                           && $stable(acc_q))
    else $error("register and to file misrouted");
  a_clear_addr: assert property ( // [RULE6]
    is_bclr |=> wr_addr_q == $past(faddr) && $stable(acc_q))
    else $error("bit clear address wrong");
  a_set_addr: assert property ( // [RULE7]
    is_bset |=> wr_addr_q == $past(faddr) && $stable(half_carry_flag_q))
    else $error("bit set address wrong");
  a_bit_keep_rest: assert property ( // [RULE13]
    is_bclr || is_bset |=> ((wr_data_q ^ $past(file_data))
                            & ~(8'h01 << $past(dp.bit_sel))) == 8'h00)
    else $error("bit op changed another bit");
  a_low_quiet: assert property ( // [RULE8]
    is_tlow |=> !wr_en_q && $stable(acc_q) && $stable(carry_q)
                && $stable(half_carry_flag_q) && $stable(zero_q))
    else $error("skip on low bit had an effect");
  a_high_quiet: assert property ( // [RULE9]
    is_thigh |=> !wr_en_q && $stable(acc_q) && $stable(carry_q)
                 && $stable(half_carry_flag_q) && $stable(zero_q))
    else $error("skip on high bit had an effect");
  a_jump_slot: assert property ( // [RULE10]
    is_jump |=> st_q == exec_pkg::ST_NOP && !wr_en_q && $stable(acc_q))
    else $error("jump did not open a nop slot");
  a_nop_wait: assert property ( // [RULE10]
    st_q == exec_pkg::ST_NOP && !instr_valid |=> st_q == exec_pkg::ST_NOP
                                                 && !discard_q && !wr_en_q)
    else $error("nop slot left without a word");
  a_discard_single: assert property ( // [RULE10]
    discard_q |=> !discard_q)
    else $error("discard pulse too long");
  a_write_source: assert property ( // [RULE3]
    !(is_add_reg || is_and_reg || is_bclr || is_bset) |=> !wr_en_q)
    else $error("write without a writing instruction");
  a_flags_quiet: assert property ( // [RULE6] [RULE7]
    !(is_add_lit || is_add_reg || is_and_lit || is_and_reg)
      |=> $stable(carry_q) && $stable(half_carry_flag_q) && $stable(zero_q))
    else $error("flags moved without an arithmetic instruction");

  c_skip_taken: cover property (is_tlow && !dp.tested ##1 instr_valid ##1 discard_q);
  c_add_carry:  cover property (is_add_lit && dp.carry && dp.half);
  c_bit_timer:  cover property (is_bset ##1 presc_clr_q);
  c_timer_wr:   cover property (presc_clr_q);
  c_jump_nop:   cover property (is_jump ##[1:4] discard_q);
endmodule
`default_nettype wire

// ==== logic/exec_pkg.sv ====
`default_nettype none
package exec_pkg;
  // ----------------------------------------
  // instruction word layout
  // ----------------------------------------
  localparam int unsigned IW        = 14;
  localparam int unsigned DW        = 8;
  localparam int unsigned AW        = 7;
  localparam int unsigned BW        = 3;
  localparam int unsigned CLS_HI    = 13;
  localparam int unsigned CLS_LO    = 12;
  localparam int unsigned BOP_HI    = 11;
  localparam int unsigned BOP_LO    = 8;
  localparam int unsigned DEST_POS  = 7;
  localparam int unsigned BIT_HI    = 9;
  localparam int unsigned BIT_LO    = 7;
  localparam int unsigned BITOP_HI  = 11;
  localparam int unsigned BITOP_LO  = 10;
  localparam int unsigned LIT_HI    = 7;
  localparam int unsigned LIT_LO    = 0;
  localparam int unsigned LADD_LO   = 9;
  // ----------------------------------------
  // opcode values
  // ----------------------------------------
  localparam logic [1:0] CLS_BYTE   = 2'h0;
  localparam logic [1:0] CLS_BIT    = 2'h1;
  localparam logic [1:0] CLS_JUMP   = 2'h2;
  localparam logic [1:0] CLS_LIT    = 2'h3;
  localparam logic [3:0] OP_ADD_REG = 4'h7;
  localparam logic [3:0] OP_AND_REG = 4'h5;
  localparam logic [1:0] OP_BCLR    = 2'h0;
  localparam logic [1:0] OP_BSET    = 2'h1;
  localparam logic [1:0] OP_TSTLOW  = 2'h2;
  localparam logic [1:0] OP_TSTHIGH = 2'h3;
  localparam logic [2:0] OP_ADD_LIT = 3'h7;
  localparam logic [3:0] OP_AND_LIT = 4'h9;
  localparam logic       DEST_ACC   = 1'b0;
  localparam logic       DEST_FILE  = 1'b1;
  // ----------------------------------------
  // addresses and reset values
  // ----------------------------------------
  localparam logic [6:0] TIMER_ADDR = 7'h01;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic       FLAG_RST   = 1'b0;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b10
  } seq_e;
endpackage
`default_nettype wire

// ==== logic/datapath_if.sv ====
`default_nettype none
interface datapath_if;
  logic [7:0] acc;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic [7:0] sum;
  logic       carry;
  logic       half;
  logic [7:0] cleared;
  logic [7:0] setv;
  logic       tested;
  modport core  (output acc, operand, bit_sel,
                 input  sum, carry, half, cleared, setv, tested);
  modport adder (input acc, operand, output sum, carry, half);
  modport bitop (input operand, bit_sel, output cleared, setv, tested);
endinterface
`default_nettype wire

// ==== logic/add_unit.sv ====
`default_nettype none
module add_unit (
  datapath_if.adder dp
);
  logic [8:0] full;
  logic [4:0] low;
  // ----------------------------------------
  // 8-bit add with nibble carry
  // ----------------------------------------
  always_comb begin
    full     = {1'b0, dp.acc} + {1'b0, dp.operand};
    low      = {1'b0, dp.acc[3:0]} + {1'b0, dp.operand[3:0]};
    dp.sum   = full[7:0];
    dp.carry = full[8];   // [RULE12]
    dp.half  = low[4];    // [RULE12]
  end
endmodule
`default_nettype wire

// ==== logic/bit_unit.sv ====
`default_nettype none
module bit_unit (
  datapath_if.bitop dp
);
  logic [7:0] hit;
  // ----------------------------------------
  // per-bit select, clear and set
  // ----------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign hit[i]        = (dp.bit_sel == 3'(i));
    assign dp.cleared[i] = hit[i] ? 1'b0 : dp.operand[i];  // [RULE13]
    assign dp.setv[i]    = hit[i] ? 1'b1 : dp.operand[i];  // [RULE13]
  end
  assign dp.tested = |(hit & dp.operand);
endmodule
`default_nettype wire

// ==== tb/add_bit_exec_tb_top.sv ====
`default_nettype none
`define CHK(n, e, g) check(n, 8'(e), 8'(g));
module add_bit_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rst_n;
  logic        instr_valid;
  logic        presc_on_timer;
  logic [13:0] instr;
  logic [7:0]  file_data;
  logic [7:0]  acc_q;
  logic [7:0]  wr_data_q;
  logic [6:0]  wr_addr_q;
  logic        carry_q;
  logic        half_carry_flag_q;
  logic        zero_q;
  logic        wr_en_q;
  logic        discard_q;
  logic        presc_clr_q;
  int          err_count;
  int          samples_checked;
  int          cycles;

  add_bit_exec DUT (.clock, .rst_n, .instr, .instr_valid, .file_data, .presc_on_timer,
    .acc_q, .carry_q, .half_carry_flag_q, .zero_q, .wr_en_q, .wr_addr_q, .wr_data_q,
    .discard_q, .presc_clr_q);

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // whole run is under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // inputs change at the falling edge, outputs are read there too
  task automatic issue(logic [13:0] iw, logic [7:0] fd, logic pt);
    instr = iw;
    file_data = fd;
    presc_on_timer = pt;
    instr_valid = 1'h1;
    @(negedge clock);
  endtask
  task automatic idle();
    instr_valid = 1'h0;
    @(negedge clock);
  endtask
  task automatic st(logic [7:0] a, logic c, logic h, logic z);
    `CHK("acc", a, acc_q)
    `CHK("carry", c, carry_q)
    `CHK("half_carry", h, half_carry_flag_q)
    `CHK("zero", z, zero_q)
  endtask
  task automatic wr(logic e, logic [6:0] ad, logic [7:0] d, logic p);
    `CHK("wr_en", e, wr_en_q)
    if (e) begin
      `CHK("wr_addr", ad, wr_addr_q)
      `CHK("wr_data", d, wr_data_q)
    end
    `CHK("presc_clr", p, presc_clr_q)
  endtask
  // leaves acc = v with carry and half carry set, v low nibble must not be f
  task automatic prime(logic [7:0] v);
    issue({6'h39, 8'h00}, 8'h00, 1'h0);
    issue({6'h3e, 8'hff}, 8'h00, 1'h0);
    issue({6'h3e, v + 8'h01}, 8'h00, 1'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_add_lit();
    logic [7:0] av [4] = '{8'h01, 8'hff, 8'h80, 8'h0f};
    logic [7:0] kv [4] = '{8'h0f, 8'h01, 8'h80, 8'hf1};
    logic [8:0] s;
    logic       h;
    for (int i = 0; i < 4; i++) begin
      issue({6'h39, 8'h00}, 8'h00, 1'h0);
      issue({6'h3e, av[i]}, 8'h00, 1'h0);
      issue({6'h3e, kv[i]}, 8'h00, 1'h0);
      s = {1'h0, av[i]} + {1'h0, kv[i]};
      h = ({1'h0, av[i][3:0]} + {1'h0, kv[i][3:0]}) > 5'h0f;
      st(s[7:0], s[8], h, s[7:0] == 8'h00);
    end
    idle();
  endtask
  task automatic t_add_reg();
    prime(8'h3c);
    issue({6'h07, 1'h1, 7'h7f}, 8'h04, 1'h0);
    st(8'h3c, 1'h0, 1'h1, 1'h0);
    wr(1'h1, 7'h7f, 8'h40, 1'h0);
    issue({6'h07, 1'h0, 7'h00}, 8'h44, 1'h0);
    st(8'h80, 1'h0, 1'h1, 1'h0);
    wr(1'h0, 7'h00, 8'h00, 1'h0);
    issue({6'h07, 1'h1, exec_pkg::TIMER_ADDR}, 8'h00, 1'h1);
    wr(1'h1, exec_pkg::TIMER_ADDR, 8'h80, 1'h1);
    issue({6'h07, 1'h1, exec_pkg::TIMER_ADDR}, 8'h00, 1'h0);
    wr(1'h1, exec_pkg::TIMER_ADDR, 8'h80, 1'h0);
    issue({6'h07, 1'h0, exec_pkg::TIMER_ADDR}, 8'h00, 1'h1);
    wr(1'h0, 7'h00, 8'h00, 1'h0);
    idle();
  endtask
  task automatic t_mask();
    prime(8'hf0);
    issue({6'h39, 8'h0f}, 8'h00, 1'h0);
    st(8'h00, 1'h1, 1'h1, 1'h1);
    prime(8'h3c);
    issue({6'h05, 1'h1, 7'h55}, 8'h0f, 1'h0);
    st(8'h3c, 1'h1, 1'h1, 1'h0);
    wr(1'h1, 7'h55, 8'h0c, 1'h0);
    issue({6'h05, 1'h0, 7'h55}, 8'hc3, 1'h0);
    st(8'h00, 1'h1, 1'h1, 1'h1);
    wr(1'h0, 7'h00, 8'h00, 1'h0);
    idle();
  endtask
  task automatic t_bits();
    logic [2:0] b;
    prime(8'h3c);
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      issue({2'h1, exec_pkg::OP_BCLR, b, 7'h20 + 7'(i)}, 8'ha5, 1'h0);
      wr(1'h1, 7'h20 + 7'(i), 8'ha5 & ~(8'h01 << b), 1'h0);
      issue({2'h1, exec_pkg::OP_BSET, b, 7'h40 + 7'(i)}, 8'h5a, 1'h0);
      wr(1'h1, 7'h40 + 7'(i), 8'h5a | (8'h01 << b), 1'h0);
      st(8'h3c, 1'h1, 1'h1, 1'h0);
    end
    issue({2'h1, exec_pkg::OP_BSET, 3'h7, exec_pkg::TIMER_ADDR}, 8'h00, 1'h1);
    wr(1'h1, exec_pkg::TIMER_ADDR, 8'h80, 1'h1);
    idle();
  endtask
  task automatic t_skip();
    logic [1:0] op;
    logic       sk;
    for (int i = 0; i < 4; i++) begin
      op = i[1] ? exec_pkg::OP_TSTHIGH : exec_pkg::OP_TSTLOW;
      sk = i[1] ? i[0] : !i[0];
      prime(8'h3c);
      issue({2'h1, op, 3'h5, 7'h30}, i[0] ? 8'h20 : 8'hdf, 1'h0);
      st(8'h3c, 1'h1, 1'h1, 1'h0);
      `CHK("discard", 1'h0, discard_q)
      // idle gap must not cancel a pending skip
      if (i[1]) begin
        idle();
      end
      issue({6'h07, 1'h1, 7'h30}, 8'h01, 1'h0);
      `CHK("discard", sk, discard_q)
      st(8'h3c, sk, sk, 1'h0);
      wr(!sk, 7'h30, 8'h3d, 1'h0);
    end
    prime(8'h3c);
    issue({3'h5, 11'h000}, 8'h00, 1'h0);
    issue({6'h3e, 8'h01}, 8'h00, 1'h0);
    `CHK("discard", 1'h1, discard_q)
    st(8'h3c, 1'h1, 1'h1, 1'h0);
    issue({6'h3e, 8'h01}, 8'h00, 1'h0);
    `CHK("discard", 1'h0, discard_q)
    st(8'h3d, 1'h0, 1'h0, 1'h0);
    idle();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'h0;
    instr_valid = 1'h0;
    instr = 14'h0000;
    file_data = 8'h00;
    presc_on_timer = 1'h0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'h1;
    st(8'h00, 1'h0, 1'h0, 1'h0);
    wr(1'h0, 7'h00, 8'h00, 1'h0);
    t_add_lit();
    t_add_reg();
    t_mask();
    t_bits();
    t_skip();
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
